//--- design/ise_status_top.sv
// status reporting hierarchy: error, measurement, operation and questionable registers
// assumes source inputs synchronous to sys_clk; rst is the power-on reset
// Notes on behaviour
// - serial parity, framing, overrun set error bits 7,6,5
// - upper limit below lower sets error bit 3
// - scaling overflow sets error bit 1
// - unused bits always read zero
// - reading error/measurement event returns then clears
// - masked error events drive instrument error summary
// - enable masks survive clear status and instrument clear
// - masks cleared at power-up only if enabled
// - limit low/high/go set measurement bits 7,6,5
// - calibration done bit 3, measurement done bit 0
// - bulk log completion sets bit 2, not abort
// - bulk log stop event sets bit 1
// - masked measurement events drive measurement summary
// - operation condition shows trigger wait and measuring
// - condition reads have no side effect
// - event registers latch changes until read or cleared
// - clear status zeroes all four event registers
// - masked operation events drive operation summary
// - questionable bits 14,12,11: fifo overwrite, high, low
// - overloads set questionable event bits 9,4,1,0
// - overload bits read zero in questionable condition
// - masked questionable events drive questionable summary
// - status byte: bits 0,3,7 carry summaries
// - error summary at standard event bit 3
`timescale 1ns/1ps
`default_nettype none

module ise_status_top
    import ise_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        power_on_clear,
    input  wire logic        clear_status,
    input  wire logic [3:0]  reg_sel,
    input  wire logic        rd_req,
    input  wire logic        wr_req,
    input  wire logic [15:0] wr_data,
    input  wire logic        serial_parity_err,
    input  wire logic        serial_framing_err,
    input  wire logic        serial_overrun_err,
    input  wire logic        limit_order_err,
    input  wire logic        scaling_overflow,
    input  wire logic        limit_active,
    input  wire logic        result_strobe,
    input  wire logic        result_below,
    input  wire logic        result_above,
    input  wire logic        calibration_done,
    input  wire logic        bulk_log_done,
    input  wire logic        bulk_log_abort,
    input  wire logic        bulk_log_stop_event,
    input  wire logic        measurement_done,
    input  wire logic        trigger_waiting,
    input  wire logic        measuring,
    input  wire logic        log_fifo_overwrite,
    input  wire logic        resistance_overload,
    input  wire logic        temperature_overload,
    input  wire logic        current_overload,
    input  wire logic        voltage_overload,
    output logic [15:0]      rd_data,
    output logic             rd_valid,
    output logic             cmd_err,
    output logic             instrument_error_summary,
    output logic             measurement_summary,
    output logic             operation_summary,
    output logic             questionable_summary,
    output logic [7:0]       status_byte_summary,
    output logic [7:0]       std_event_summary
);

    // ==========================================================
    // source edge detection
    localparam int NSRC = 16;
    localparam int S_PAR  = 0;
    localparam int S_FRM  = 1;
    localparam int S_OVR  = 2;
    localparam int S_LIM  = 3;
    localparam int S_SCL  = 4;
    localparam int S_CAL  = 5;
    localparam int S_BLD  = 6;
    localparam int S_BLS  = 7;
    localparam int S_MDN  = 8;
    localparam int S_TRW  = 9;
    localparam int S_MSR  = 10;
    localparam int S_FIFO = 11;
    localparam int S_RES  = 12;
    localparam int S_TMP  = 13;
    localparam int S_CUR  = 14;
    localparam int S_VLT  = 15;

    logic [NSRC-1:0] src_level;
    logic [NSRC-1:0] src_rise;

    always_comb
    begin
        src_level         = '0;
        src_level[S_PAR]  = serial_parity_err;
        src_level[S_FRM]  = serial_framing_err;
        src_level[S_OVR]  = serial_overrun_err;
        src_level[S_LIM]  = limit_order_err;
        src_level[S_SCL]  = scaling_overflow;
        src_level[S_CAL]  = calibration_done;
        src_level[S_BLD]  = bulk_log_done & ~bulk_log_abort;
        src_level[S_BLS]  = bulk_log_stop_event;
        src_level[S_MDN]  = measurement_done;
        src_level[S_TRW]  = trigger_waiting;
        src_level[S_MSR]  = measuring;
        src_level[S_FIFO] = log_fifo_overwrite;
        src_level[S_RES]  = resistance_overload;
        src_level[S_TMP]  = temperature_overload;
        src_level[S_CUR]  = current_overload;
        src_level[S_VLT]  = voltage_overload;
    end

    ise_edge #(
        .W     (NSRC)
    ) u_edge (
        .sys_clk (sys_clk),
        .rst     (rst),
        .level   (src_level),
        .rise    (src_rise)
    );

    // ==========================================================
    // limit verdict and condition registers
    logic        lim_low;
    logic        lim_high;
    logic        lim_go;
    logic        lim_low_q;
    logic        lim_high_q;
    logic        next_lim_low;
    logic        next_lim_high;
    logic [15:0] oper_cond;
    logic [15:0] ques_cond;
    logic [15:0] next_oper_cond;
    logic [15:0] next_ques_cond;

    // verdicts only count while limit calculation is on
    assign lim_low  = result_strobe & limit_active & result_below;
    assign lim_high = result_strobe & limit_active & result_above & ~result_below;
    assign lim_go   = result_strobe & limit_active & ~result_above & ~result_below;

    always_comb
    begin
        next_lim_low  = lim_low_q;
        next_lim_high = lim_high_q;
        if (!limit_active)
        begin
            next_lim_low  = 1'b0;
            next_lim_high = 1'b0;
        end
        else if (result_strobe)
        begin
            next_lim_low  = lim_low;
            next_lim_high = lim_high;
        end
        next_oper_cond = 16'h0000;
        next_oper_cond[ISE_OPER_TRIGWAIT]  = trigger_waiting;
        next_oper_cond[ISE_OPER_MEASURING] = measuring;
        // overload positions stay zero here: overload is event-only
        next_ques_cond = 16'h0000;
        next_ques_cond[ISE_QUES_FIFO] = log_fifo_overwrite;
        next_ques_cond[ISE_QUES_HIGH] = next_lim_high;
        next_ques_cond[ISE_QUES_LOW]  = next_lim_low;
        next_ques_cond = next_ques_cond & ISE_COND_QUES;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            lim_low_q  <= 1'b0;
            lim_high_q <= 1'b0;
            oper_cond  <= 16'h0000;
            ques_cond  <= 16'h0000;
        end
        else
        begin
            lim_low_q  <= next_lim_low;
            lim_high_q <= next_lim_high;
            oper_cond  <= next_oper_cond;
            ques_cond  <= next_ques_cond;
        end
    end

    // ==========================================================
    // event sets per group
    ise_evt_if evt [ISE_NGRP] ();

    logic [15:0] set_err;
    logic [15:0] set_meas;
    logic [15:0] set_oper;
    logic [15:0] set_ques;

    always_comb
    begin
        set_err  = 16'h0000;
        set_meas = 16'h0000;
        set_oper = 16'h0000;
        set_ques = 16'h0000;
        set_err[ISE_ERR_PARITY]   = src_rise[S_PAR];
        set_err[ISE_ERR_FRAMING]  = src_rise[S_FRM];
        set_err[ISE_ERR_OVERRUN]  = src_rise[S_OVR];
        set_err[ISE_ERR_LIMORDER] = src_rise[S_LIM];
        set_err[ISE_ERR_SCALING]  = src_rise[S_SCL];
        set_meas[ISE_MEAS_LOW]    = lim_low;
        set_meas[ISE_MEAS_HIGH]   = lim_high;
        set_meas[ISE_MEAS_GO]     = lim_go;
        set_meas[ISE_MEAS_CAL]    = src_rise[S_CAL];
        set_meas[ISE_MEAS_BLDONE] = src_rise[S_BLD];
        set_meas[ISE_MEAS_BLSTOP] = src_rise[S_BLS];
        set_meas[ISE_MEAS_DONE]   = src_rise[S_MDN];
        set_oper[ISE_OPER_TRIGWAIT]  = src_rise[S_TRW];
        set_oper[ISE_OPER_MEASURING] = src_rise[S_MSR];
        set_ques[ISE_QUES_FIFO]   = src_rise[S_FIFO];
        set_ques[ISE_QUES_HIGH]   = lim_high;
        set_ques[ISE_QUES_LOW]    = lim_low;
        set_ques[ISE_QUES_RES]    = src_rise[S_RES];
        set_ques[ISE_QUES_TEMP]   = src_rise[S_TMP];
        set_ques[ISE_QUES_CURR]   = src_rise[S_CUR];
        set_ques[ISE_QUES_VOLT]   = src_rise[S_VLT];
    end

    assign evt[ISE_GRP_ERR].set  = set_err;
    assign evt[ISE_GRP_MEAS].set = set_meas;
    assign evt[ISE_GRP_OPER].set = set_oper;
    assign evt[ISE_GRP_QUES].set = set_ques;

    // ==========================================================
    // command decode
    logic                is_read_sel [ISE_NGRP];
    logic                is_mask_sel [ISE_NGRP];
    logic [15:0]         grp_event   [ISE_NGRP];
    logic [15:0]         grp_enable  [ISE_NGRP];
    logic [ISE_NGRP-1:0] grp_summary;

    localparam logic [3:0]  EV_SEL [ISE_NGRP] = '{ISE_SEL_ERR_EVENT, ISE_SEL_MEAS_EVENT,
                                                   ISE_SEL_OPER_EVENT, ISE_SEL_QUES_EVENT};
    localparam logic [3:0]  EN_SEL [ISE_NGRP] = '{ISE_SEL_ERR_ENABLE, ISE_SEL_MEAS_ENABLE,
                                                   ISE_SEL_OPER_ENABLE, ISE_SEL_QUES_ENABLE};
    localparam logic [15:0] USED   [ISE_NGRP] = '{ISE_USED_ERR, ISE_USED_MEAS,
                                                   ISE_USED_OPER, ISE_USED_QUES};

    genvar g;
    generate
        for (g = 0; g < ISE_NGRP; g++)
        begin : g_grp
            assign is_read_sel[g]        = rd_req && (reg_sel == EV_SEL[g]);
            assign is_mask_sel[g]        = wr_req && (reg_sel == EN_SEL[g]);
            assign evt[g].read_clr       = is_read_sel[g];
            assign evt[g].clear_status   = clear_status;
            assign evt[g].power_clear    = power_on_clear;
            assign evt[g].mask_wr        = is_mask_sel[g];
            assign evt[g].mask_data      = wr_data;
            assign grp_event[g]          = evt[g].event_bits;
            assign grp_enable[g]         = evt[g].enable;
            assign grp_summary[g]        = evt[g].summary;

            ise_event_reg #(
                .USED (USED[g])
            ) u_evt (
                .sys_clk (sys_clk),
                .rst     (rst),
                .bus     (evt[g])
            );
        end
    endgenerate

    // ==========================================================
    // query answers and summaries
    logic [15:0] next_rd_data;
    logic        next_rd_valid;
    logic        next_cmd_err;
    logic [7:0]  next_stb;
    logic [7:0]  next_esr;

    always_comb
    begin
        next_rd_data  = 16'h0000;
        next_rd_valid = rd_req;
        next_cmd_err  = 1'b0;
        // condition reads only sample; nothing is cleared
        case (reg_sel)
            ISE_SEL_ERR_EVENT:   next_rd_data = grp_event[ISE_GRP_ERR];
            ISE_SEL_ERR_ENABLE:  next_rd_data = grp_enable[ISE_GRP_ERR];
            ISE_SEL_MEAS_EVENT:  next_rd_data = grp_event[ISE_GRP_MEAS];
            ISE_SEL_MEAS_ENABLE: next_rd_data = grp_enable[ISE_GRP_MEAS];
            ISE_SEL_OPER_COND:   next_rd_data = oper_cond;
            ISE_SEL_OPER_EVENT:  next_rd_data = grp_event[ISE_GRP_OPER];
            ISE_SEL_OPER_ENABLE: next_rd_data = grp_enable[ISE_GRP_OPER];
            ISE_SEL_QUES_COND:   next_rd_data = ques_cond;
            ISE_SEL_QUES_EVENT:  next_rd_data = grp_event[ISE_GRP_QUES];
            ISE_SEL_QUES_ENABLE: next_rd_data = grp_enable[ISE_GRP_QUES];
            default:
            begin
                next_rd_data = 16'h0000;
                next_cmd_err = rd_req;
            end
        endcase
        if (!rd_req)
            next_rd_data = rd_data;
        // a write is only legal to an enable mask
        if (wr_req && (is_mask_sel[ISE_GRP_ERR] | is_mask_sel[ISE_GRP_MEAS] |
                       is_mask_sel[ISE_GRP_OPER] | is_mask_sel[ISE_GRP_QUES]) == 1'b0)
            next_cmd_err = 1'b1;
        if (rd_req && wr_req)
            next_cmd_err = 1'b1;
        next_stb = 8'h00;
        next_stb[ISE_STB_MEAS] = grp_summary[ISE_GRP_MEAS];
        next_stb[ISE_STB_QUES] = grp_summary[ISE_GRP_QUES];
        next_stb[ISE_STB_OPER] = grp_summary[ISE_GRP_OPER];
        next_esr = 8'h00;
        next_esr[ISE_ESR_ERR]  = grp_summary[ISE_GRP_ERR];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rd_data                  <= 16'h0000;
            rd_valid                 <= 1'b0;
            cmd_err                  <= 1'b0;
            instrument_error_summary <= 1'b0;
            measurement_summary      <= 1'b0;
            operation_summary        <= 1'b0;
            questionable_summary     <= 1'b0;
            status_byte_summary      <= 8'h00;
            std_event_summary        <= 8'h00;
        end
        else
        begin
            rd_data                  <= next_rd_data;
            rd_valid                 <= next_rd_valid;
            cmd_err                  <= next_cmd_err;
            instrument_error_summary <= grp_summary[ISE_GRP_ERR];
            measurement_summary      <= grp_summary[ISE_GRP_MEAS];
            operation_summary        <= grp_summary[ISE_GRP_OPER];
            questionable_summary     <= grp_summary[ISE_GRP_QUES];
            status_byte_summary      <= next_stb;
            std_event_summary        <= next_esr;
        end
    end
endmodule : ise_status_top

`default_nettype wire

//--- design/ise_pkg.sv
// package for the instrument status event hierarchy: selectors, bit positions, used-bit masks
// assumes every includer imports the whole package
package ise_pkg;

    // ==========================================================
    // register selectors for the query/command port
    typedef enum logic [3:0] {
        ISE_SEL_ERR_EVENT  = 4'h0,
        ISE_SEL_ERR_ENABLE = 4'h1,
        ISE_SEL_MEAS_EVENT = 4'h2,
        ISE_SEL_MEAS_ENABLE = 4'h3,
        ISE_SEL_OPER_COND  = 4'h4,
        ISE_SEL_OPER_EVENT = 4'h5,
        ISE_SEL_OPER_ENABLE = 4'h6,
        ISE_SEL_QUES_COND  = 4'h7,
        ISE_SEL_QUES_EVENT = 4'h8,
        ISE_SEL_QUES_ENABLE = 4'h9
    } ise_reg_sel_t;

    // ==========================================================
    // event register groups
    localparam int ISE_NGRP     = 4;
    localparam int ISE_GRP_ERR  = 0;
    localparam int ISE_GRP_MEAS = 1;
    localparam int ISE_GRP_OPER = 2;
    localparam int ISE_GRP_QUES = 3;
    localparam int ISE_DW       = 16;

    // ==========================================================
    // instrument error bits
    localparam int ISE_ERR_PARITY   = 7;
    localparam int ISE_ERR_FRAMING  = 6;
    localparam int ISE_ERR_OVERRUN  = 5;
    localparam int ISE_ERR_LIMORDER = 3;
    localparam int ISE_ERR_SCALING  = 1;

    // measurement event bits
    localparam int ISE_MEAS_LOW    = 7;
    localparam int ISE_MEAS_HIGH   = 6;
    localparam int ISE_MEAS_GO     = 5;
    localparam int ISE_MEAS_CAL    = 3;
    localparam int ISE_MEAS_BLDONE = 2;
    localparam int ISE_MEAS_BLSTOP = 1;
    localparam int ISE_MEAS_DONE   = 0;

    // operation bits
    localparam int ISE_OPER_TRIGWAIT = 5;
    localparam int ISE_OPER_MEASURING = 4;

    // questionable bits
    localparam int ISE_QUES_FIFO  = 14;
    localparam int ISE_QUES_HIGH  = 12;
    localparam int ISE_QUES_LOW   = 11;
    localparam int ISE_QUES_RES   = 9;
    localparam int ISE_QUES_TEMP  = 4;
    localparam int ISE_QUES_CURR  = 1;
    localparam int ISE_QUES_VOLT  = 0;

    // summary positions in the status byte and standard event register
    localparam int ISE_STB_MEAS = 0;
    localparam int ISE_STB_QUES = 3;
    localparam int ISE_STB_OPER = 7;
    localparam int ISE_ESR_ERR  = 3;

    // ==========================================================
    // used-bit masks; unused positions always read zero
    localparam logic [15:0] ISE_USED_ERR  = 16'h00EA;
    localparam logic [15:0] ISE_USED_MEAS = 16'h00EF;
    localparam logic [15:0] ISE_USED_OPER = 16'h0030;
    localparam logic [15:0] ISE_USED_QUES = 16'h5A13;
    localparam logic [15:0] ISE_COND_QUES = 16'h5800;

endpackage : ise_pkg

//--- design/ise_evt_if.sv
// carrier between the top and one event register group
// assumes a single clock domain, all signals sampled on sys_clk
`timescale 1ns/1ps
`default_nettype none

interface ise_evt_if;
    logic [15:0] set;
    logic        read_clr;
    logic        clear_status;
    logic        power_clear;
    logic        mask_wr;
    logic [15:0] mask_data;
    logic [15:0] event_bits;
    logic [15:0] enable;
    logic        summary;

    modport regs (
        input  set,
        input  read_clr,
        input  clear_status,
        input  power_clear,
        input  mask_wr,
        input  mask_data,
        output event_bits,
        output enable,
        output summary
    );

    modport ctrl (
        output set,
        output read_clr,
        output clear_status,
        output power_clear,
        output mask_wr,
        output mask_data,
        input  event_bits,
        input  enable,
        input  summary
    );
endinterface : ise_evt_if

`default_nettype wire

//--- design/ise_edge.sv
// rising-edge detector for a vector of source conditions
// assumes sources are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none

module ise_edge
    import ise_pkg::*;
#(
    parameter int W = 16
)(
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] level,
    output logic [W-1:0]      rise
);
    logic [W-1:0] prev;
    logic [W-1:0] next_prev;

    // ==========================================================
    // edge logic
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            assign rise[g]      = level[g] & ~prev[g];
            assign next_prev[g] = level[g];
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            prev <= '0;
        else
            prev <= next_prev;
    end
endmodule : ise_edge

`default_nettype wire

//--- design/ise_event_reg.sv
// one event register with its enable mask and summary
// assumes rst marks power-up and power_clear carries the power-on clear setting
`timescale 1ns/1ps
`default_nettype none

module ise_event_reg
    import ise_pkg::*;
#(
    parameter logic [15:0] USED = 16'hFFFF
)(
    input  wire logic sys_clk,
    input  wire logic rst,
    ise_evt_if.regs   bus
);
    logic [15:0] event_q;
    logic [15:0] enable_q;
    logic [15:0] next_event;
    logic [15:0] next_enable;

    // ==========================================================
    // next values
    always_comb
    begin
        next_event  = event_q;
        next_enable = enable_q;
        if (bus.read_clr || bus.clear_status)
            next_event = '0;
        // set wins over a coinciding clear
        next_event = (next_event | bus.set) & USED;
        // clear status leaves the mask alone
        if (bus.mask_wr)
            next_enable = bus.mask_data & USED;
        if (rst)
            next_enable = bus.power_clear ? 16'h0000 : enable_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            event_q <= '0;
        else
            event_q <= next_event;
        enable_q <= next_enable;
    end

    assign bus.event_bits = event_q;
    assign bus.enable     = enable_q;
    assign bus.summary    = |(event_q & enable_q);
endmodule : ise_event_reg

`default_nettype wire

//--- testbench/ise_status_properties.sv
// checker: port assertions of the status hierarchy
// assumes it is bound onto ise_status_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ise_status_properties
    import ise_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [3:0]  reg_sel,
    input wire logic        rd_req,
    input wire logic        wr_req,
    input wire logic [15:0] rd_data,
    input wire logic        rd_valid,
    input wire logic        cmd_err,
    input wire logic [7:0]  status_byte_summary,
    input wire logic [7:0]  std_event_summary
);
    // ==========================================
    // query steps
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_query;
        rd_req && !wr_req && reg_sel < 4'hA;
    endsequence
    sequence s_answer;
        rd_valid && !cmd_err;
    endsequence
    // ==========================================
    // assertions
    a_query_answered: assert property (s_query |=> s_answer)
        else $error("query not answered");
    a_answer_cause: assert property (rd_valid |-> $past(rd_req))
        else $error("answer without query");
    a_unmapped_zero: assert property (rd_req && reg_sel > 4'h9 |=> cmd_err && rd_data == '0)
        else $error("unmapped read not refused");
    a_err_unused: assert property (rd_valid && $past(reg_sel) < 4'h2 |-> (rd_data & ~ISE_USED_ERR) == '0)
        else $error("error register unused bit set");
    a_oper_cond: assert property (rd_valid && $past(reg_sel) == 4'h4 |-> (rd_data & ~ISE_USED_OPER) == '0)
        else $error("operation condition unused bit set");
    a_ques_overload: assert property (rd_valid && $past(reg_sel) == 4'h7 |-> (rd_data & ~ISE_COND_QUES) == '0)
        else $error("overload seen in condition");
    a_stb_unused: assert property ((status_byte_summary & 8'h76) == 8'h00)
        else $error("status byte unused bit set");
    a_esr_unused: assert property ((std_event_summary & 8'hF7) == 8'h00)
        else $error("standard event unused bit set");
endmodule : ise_status_properties

bind ise_status_top ise_status_properties u_props (.sys_clk, .rst, .reg_sel, .rd_req, .wr_req, .rd_data,
    .rd_valid, .cmd_err, .status_byte_summary, .std_event_summary);
`default_nettype wire

//--- testbench/ise_host_model.sv
// host model: remote controller issuing queries and mask commands
// assumes the one-cycle command port of ise_status_top
`timescale 1ns/1ps
`default_nettype none
module ise_host_model (
    input  wire logic   sys_clk,
    output logic        rd_req,
    output logic        wr_req,
    output logic [3:0]  reg_sel,
    output logic [15:0] wr_data
);
    initial
    begin
        rd_req = 1'b0;
        wr_req = 1'b0;
        reg_sel = 4'h0;
        wr_data = 16'h0000;
    end
    // selector and data are inverted once released, so stale values never look valid
    task automatic cmd(input logic w, input logic [3:0] s, input logic [15:0] d);
        @(posedge sys_clk);
        rd_req <= !w;
        wr_req <= w;
        reg_sel <= s;
        wr_data <= d;
        @(posedge sys_clk);
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        reg_sel <= ~s;
        wr_data <= ~d;
    endtask : cmd
endmodule : ise_host_model
`default_nettype wire

//--- testbench/tb_instrument_status_event_hierarchy.sv
// testbench: drives sources and queries, scores read answers from a queue
// assumes ise_status_top, its bound checker and ise_host_model
`timescale 1ns/1ps
`default_nettype none
module tb_instrument_status_event_hierarchy;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        poc = 1'b1;
    logic        clr = 1'b0;
    logic        lim = 1'b0;
    logic        stb = 1'b0;
    logic        below = 1'b0;
    logic        above = 1'b0;
    logic        abort = 1'b0;
    logic [15:0] src = 16'h0000;
    logic        rd_req, wr_req, rd_valid, cmd_err;
    logic [3:0]  reg_sel, sum, s;
    logic [15:0] wr_data, rd_data, r;
    logic [7:0]  status_byte_summary, std_event_summary;
    logic [15:0] exp_q[$];
    logic [3:0]  ensel [4] = '{4'h1, 4'h3, 4'h6, 4'h9};
    logic [15:0] used [4] = '{16'h00EA, 16'h00EF, 16'h0030, 16'h5A13};
    int          bitp [14] = '{7, 6, 5, 3, 1, 3, 2, 1, 0, 14, 9, 4, 1, 0};
    int          g;
    int          error_cnt = 0;
    int          tests_run = 0;
    always #12.5 sys_clk = ~sys_clk;
    ise_host_model u_host (.sys_clk, .rd_req, .wr_req, .reg_sel, .wr_data);
    ise_status_top u_dut (.sys_clk, .rst, .power_on_clear(poc), .clear_status(clr), .reg_sel, .rd_req,
        .wr_req, .wr_data, .serial_parity_err(src[0]), .serial_framing_err(src[1]),
        .serial_overrun_err(src[2]), .limit_order_err(src[3]), .scaling_overflow(src[4]),
        .limit_active(lim), .result_strobe(stb), .result_below(below), .result_above(above),
        .calibration_done(src[5]), .bulk_log_done(src[6]), .bulk_log_abort(abort),
        .bulk_log_stop_event(src[7]), .measurement_done(src[8]), .trigger_waiting(src[14]),
        .measuring(src[15]), .log_fifo_overwrite(src[9]), .resistance_overload(src[10]),
        .temperature_overload(src[11]), .current_overload(src[12]), .voltage_overload(src[13]),
        .rd_data, .rd_valid, .cmd_err, .instrument_error_summary(sum[0]), .measurement_summary(sum[1]),
        .operation_summary(sum[2]), .questionable_summary(sum[3]), .status_byte_summary, .std_event_summary);
    // ==========================================
    // tasks
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
        tests_run++;
        if (v !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    task automatic rd(input logic [3:0] sel, input logic [15:0] e);
        exp_q.push_back(e);
        u_host.cmd(1'b0, sel, 16'h0000);
    endtask : rd
    task automatic pulse(input int i);
        @(posedge sys_clk);
        src[i] <= 1'b1;
        @(posedge sys_clk);
        src[i] <= 1'b0;
    endtask : pulse
    task automatic do_rst();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_rst
    task automatic print_verdict();
        if (error_cnt == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // ==========================================
    // answer monitor; an answer with no note expects unknown and so fails
    always @(posedge sys_clk)
    begin
        if (rd_valid === 1'b1)
            chk("rd_data", exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX, rd_data);
    end
    initial
    begin
        #(25 * 20000);
        error_cnt++;
        print_verdict();
    end
    // ==========================================
    // main sequence
    initial
    begin
        void'($urandom(82699));
        do_rst();
        for (int k = 0; k < 4; k++)
        begin
            r = 16'($urandom);
            u_host.cmd(1'b1, ensel[k], r);
            rd(ensel[k], r & used[k]);
            u_host.cmd(1'b1, ensel[k], 16'hFFFF);
        end
        for (int i = 0; i < 14; i++)
        begin
            g = i < 5 ? 0 : i < 9 ? 1 : 3;
            s = g == 0 ? 4'h0 : g == 1 ? 4'h2 : 4'h8;
            pulse(i);
            repeat (4) @(posedge sys_clk);
            chk("summary", 16'(4'h1 << g), 16'(sum));
            chk("stb_esr", g == 0 ? 16'h0008 : g == 1 ? 16'h0100 : 16'h0800, {status_byte_summary, std_event_summary});
            rd(s, 16'h0001 << bitp[i]);
            rd(s, 16'h0000);
        end
        src[15:14] <= 2'b11;
        repeat (4) @(posedge sys_clk);
        chk("oper", 16'h0003, 16'({status_byte_summary[7], sum[2]}));
        rd(4'h4, 16'h0030);
        rd(4'h4, 16'h0030);
        rd(4'h5, 16'h0030);
        rd(4'h5, 16'h0000);
        src[15:14] <= 2'b00;
        lim <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            @(posedge sys_clk);
            below <= k == 0;
            above <= k == 1;
            stb <= 1'b1;
            @(posedge sys_clk);
            stb <= 1'b0;
            rd(4'h2, 16'h0080 >> k);
            for (int j = 7; j < 9; j++)
                rd(4'(j), k == 0 ? 16'h0800 : k == 1 ? 16'h1000 : 16'h0000);
        end
        abort <= 1'b1;
        pulse(6);
        rd(4'h2, 16'h0000);
        abort <= 1'b0;
        fork
            pulse(0);
            rd(4'h0, 16'h0000);
        join
        rd(4'h0, 16'h0080);
        pulse(1);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h00EA);
        poc <= 1'b0;
        do_rst();
        rd(4'h3, 16'h00EF);
        poc <= 1'b1;
        do_rst();
        rd(4'h3, 16'h0000);
        rd(4'hC, 16'h0000);
        repeat (4) @(posedge sys_clk);
        print_verdict();
    end
endmodule : tb_instrument_status_event_hierarchy
`default_nettype wire
